// ### logic/sram_scan_tap.sv
// Boundary-scan test port of the SRAM: instruction, bypass, ID and boundary chains
//
// Behaviour
// - One-bit bypass register, cleared under bypass
// - Capture-DR loads ring, Shift-DR shifts it
// - One bit per ball, TDI at MSB
// - Identification captures hardwired 32-bit value
// - Three-bit instruction, three codes reserved
// - Instruction applied only at Update-IR
// - All-zero code samples and forces high impedance
// - Identification preset at power-up and reset
// - Sample-Z shifts boundary chain, outputs high impedance
// - Sample/preload snapshots balls, SRAM undisturbed
// - Update-DR under sample/preload does nothing
// - No core drive, no buffer preload
// - State advances on test clock rise
// - Bypass shortens chain to one bit
// - Decode the five functional codes, three reserved
// - Capture-IR loads 01 into low bits
// - Five high mode-select rises reset port
// - Sample rising, drive falling, TDO only shifting
`include "scan_tap_defs.svh"
module sram_scan_tap
	import scan_tap_pkg::*;
(
	// System clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// Test port pins
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe_n,
	// Levels on the SRAM input and bidirectional balls
	input  wire logic [`BSR_W-1:0]    ring_in,
	// Force all SRAM outputs to high impedance
	output logic                      sram_hiz
);
	import scan_tap_pkg::*;

	// Synchronisers for the pins
	logic [1:0]            tck_sync_ff;  // Test clock, two stages
	logic [1:0]            tms_sync_ff;  // Mode select
	logic [1:0]            tdi_sync_ff;  // Serial in
	logic                  tck_old_ff;   // Previous synced clock
	logic                  rise;         // Test clock rise event
	logic                  fall;         // Test clock fall event
	logic [1:0]            nxt_tck_sync; // Next synchroniser stages
	logic [1:0]            nxt_tms_sync;
	logic [1:0]            nxt_tdi_sync;
	logic                  nxt_tck_old;

	// Chains and controls
	tap_state_t            state;        // Controller state
	logic [`IR_W-1:0]      ir_sh_ff;     // Instruction shift stage
	logic [`IR_W-1:0]      nxt_ir_sh;
	logic [`IR_W-1:0]      ir_ff;        // Active instruction
	logic [`IR_W-1:0]      nxt_ir;
	logic                  byp_ff;       // Bypass bit
	logic                  nxt_byp;
	logic [`ID_W-1:0]      id_ff;        // Identification chain
	logic [`ID_W-1:0]      nxt_id;
	logic [`BSR_W-1:0]     bsr_ff;       // Boundary chain
	logic [`BSR_W-1:0]     nxt_bsr;
	logic                  tdo_ff;       // Serial out
	logic                  nxt_tdo;
	logic                  oe_n_ff;      // Serial out enable, low drives
	logic                  nxt_oe_n;
	logic                  hiz_ff;       // Output high-impedance force
	logic                  nxt_hiz;

	// Chain selected by an instruction
	function automatic logic [1:0] sel_chain(input logic [`IR_W-1:0] code);
		case (code)
			`IR_IDCODE:   sel_chain = 2'h1;
			`IR_EXTEST,
			`IR_SAMPLE_Z,
			`IR_SAMPLE:   sel_chain = 2'h2;
			default:      sel_chain = 2'h0; // Bypass and reserved
		endcase
	endfunction

	// Instruction forces SRAM outputs off
	function automatic logic forces_hiz(input logic [`IR_W-1:0] code);
		forces_hiz = (code == `IR_EXTEST) || (code == `IR_SAMPLE_Z);
	endfunction

	// Next synchroniser stages; only the second stage feeds the edge finder
	always_comb
	begin
		nxt_tck_sync = {tck_sync_ff[0], tck};
		nxt_tms_sync = {tms_sync_ff[0], tms};
		nxt_tdi_sync = {tdi_sync_ff[0], tdi};
		nxt_tck_old  = tck_sync_ff[1];
	end

	// Pin synchronisers and edge finder
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tck_sync_ff <= 2'h0;
			tms_sync_ff <= 2'h3;
			tdi_sync_ff <= 2'h3;
			tck_old_ff  <= 1'h0;
		end
		else
		begin
			tck_sync_ff <= nxt_tck_sync;
			tms_sync_ff <= nxt_tms_sync;
			tdi_sync_ff <= nxt_tdi_sync;
			tck_old_ff  <= nxt_tck_old;
		end
	end

	// Edges seen from the second stage only
	assign rise = tck_sync_ff[1] & ~tck_old_ff;
	assign fall = ~tck_sync_ff[1] & tck_old_ff;

	// Controller
	tap_fsm tap_fsm_i
	(
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.rise     (rise),
		.mode_sel (tms_sync_ff[1]),
		.state    (state)
	);

	// Instruction path
	always_comb
	begin
		nxt_ir_sh = ir_sh_ff;
		nxt_ir    = ir_ff;
		if (state == ST_RESET)
		begin
			nxt_ir    = `IR_IDCODE;
			nxt_ir_sh = `IR_IDCODE;
		end
		else if (rise)
		begin
			case (state)
				ST_CAP_IR: nxt_ir_sh = `IR_CAPTURE;
				ST_SH_IR:  nxt_ir_sh = {tdi_sync_ff[1], ir_sh_ff[`IR_W-1:1]};
				ST_UPD_IR: nxt_ir    = ir_sh_ff;
				default:   nxt_ir_sh = ir_sh_ff;
			endcase
		end
	end

	// Data chains, capture and shift on test clock rises
	always_comb
	begin
		nxt_byp = byp_ff;
		nxt_id  = id_ff;
		nxt_bsr = bsr_ff;
		if (rise)
		begin
			case (state)
				ST_CAP_DR:
				begin
					case (sel_chain(ir_ff))
						2'h1:    nxt_id  = `ID_VALUE;
						2'h2:    nxt_bsr = ring_in;
						default: nxt_byp = `BYP_RESET;
					endcase
				end
				ST_SH_DR:
				begin
					case (sel_chain(ir_ff))
						2'h1:    nxt_id  = {tdi_sync_ff[1], id_ff[`ID_W-1:1]};
						2'h2:    nxt_bsr = {tdi_sync_ff[1], bsr_ff[`BSR_W-1:1]};
						default: nxt_byp = tdi_sync_ff[1];
					endcase
				end
				// Update-DR preloads nothing, same as Pause-DR
				default: nxt_byp = byp_ff;
			endcase
		end
	end

	// Serial out, moved on test clock falls, driven only while shifting
	always_comb
	begin
		nxt_tdo  = tdo_ff;
		nxt_oe_n = oe_n_ff;
		if (fall)
		begin
			nxt_oe_n = 1'h1;
			if (state == ST_SH_IR)
			begin
				nxt_tdo  = ir_sh_ff[0];
				nxt_oe_n = 1'h0;
			end
			else if (state == ST_SH_DR)
			begin
				nxt_oe_n = 1'h0;
				case (sel_chain(ir_ff))
					2'h1:    nxt_tdo = id_ff[0];
					2'h2:    nxt_tdo = bsr_ff[0];
					default: nxt_tdo = byp_ff;
				endcase
			end
		end
		if (state == ST_RESET)
			nxt_oe_n = 1'h1;
	end

	// High-impedance force follows the active instruction
	always_comb
	begin
		nxt_hiz = forces_hiz(ir_ff);
	end

	// Registers
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ir_sh_ff <= `IR_IDCODE;
			ir_ff    <= `IR_IDCODE;
			byp_ff   <= `BYP_RESET;
			id_ff    <= '0;
			bsr_ff   <= '0;
			tdo_ff   <= 1'h0;
			oe_n_ff  <= 1'h1;
			hiz_ff   <= 1'h0;
		end
		else
		begin
			ir_sh_ff <= nxt_ir_sh;
			ir_ff    <= nxt_ir;
			byp_ff   <= nxt_byp;
			id_ff    <= nxt_id;
			bsr_ff   <= nxt_bsr;
			tdo_ff   <= nxt_tdo;
			oe_n_ff  <= nxt_oe_n;
			hiz_ff   <= nxt_hiz;
		end
	end

	assign tdo      = tdo_ff;
	assign tdo_oe_n = oe_n_ff;
	assign sram_hiz = hiz_ff;

	// Checks
	a_ir_reset_id: assert property (@(posedge ref_clk) disable iff (!nrst)
		state == ST_RESET |=> ir_ff == `IR_IDCODE)
		else $error("instruction not preset to identification");
	a_ir_update_only: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ir_ff != $past(ir_ff)) |-> ($past(state) == ST_UPD_IR || $past(state) == ST_RESET))
		else $error("instruction changed outside update");
	a_cap_ir_pattern: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_CAP_IR) |=> ir_sh_ff[1:0] == 2'h1)
		else $error("capture pattern wrong");
	a_id_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_CAP_DR && ir_ff == `IR_IDCODE) |=> id_ff == `ID_VALUE)
		else $error("identification not captured");
	a_bsr_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_CAP_DR && sel_chain(ir_ff) == 2'h2)
		|=> bsr_ff == $past(ring_in))
		else $error("boundary capture wrong");
	a_byp_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_CAP_DR && ir_ff == `IR_BYPASS) |=> byp_ff == 1'h0)
		else $error("bypass not cleared");
	a_hiz_codes: assert property (@(posedge ref_clk) disable iff (!nrst)
		##1 sram_hiz == ($past(ir_ff) == `IR_EXTEST || $past(ir_ff) == `IR_SAMPLE_Z))
		else $error("high-impedance force wrong");
	a_upd_dr_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state == ST_UPD_DR) |=> $stable(bsr_ff) && $stable(sram_hiz))
		else $error("update changed boundary chain");
	a_tdo_idle_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		(fall && state != ST_SH_DR && state != ST_SH_IR) |=> tdo_oe_n)
		else $error("serial out driven outside shift");

	// Shift and update checks, one serial step each
	a_tdo_shift_on: assert property (@(posedge ref_clk) disable iff (!nrst)
		(fall && (state == ST_SH_DR || state == ST_SH_IR)) |=> !tdo_oe_n)
		else $error("serial out not driven while shifting");
	a_ir_shift_in: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_SH_IR) |=> ir_sh_ff == {$past(tdi_sync_ff[1]), $past(ir_sh_ff[2:1])})
		else $error("instruction shift wrong");
	a_ir_apply: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_UPD_IR) |=> ir_ff == $past(ir_sh_ff))
		else $error("instruction not applied at update");
	a_byp_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_SH_DR && sel_chain(ir_ff) == 2'h0) |=> byp_ff == $past(tdi_sync_ff[1]))
		else $error("bypass bit shift wrong");
	a_bsr_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_SH_DR && sel_chain(ir_ff) == 2'h2)
		|=> bsr_ff == {$past(tdi_sync_ff[1]), $past(bsr_ff[`BSR_W-1:1])})
		else $error("boundary chain shift wrong");
	a_id_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rise && state == ST_SH_DR && sel_chain(ir_ff) == 2'h1) |=> id_ff[`ID_W-1] == $past(tdi_sync_ff[1]))
		else $error("identification shift wrong");
	a_tdo_bsr_lsb: assert property (@(posedge ref_clk) disable iff (!nrst)
		(fall && state == ST_SH_DR && sel_chain(ir_ff) == 2'h2) |=> tdo == $past(bsr_ff[0]))
		else $error("boundary chain not leaving at its low end");
endmodule

// ### logic/scan_tap_defs.svh
// Constants for the boundary-scan test port: codes, widths, fixed values
`ifndef SCAN_TAP_DEFS_SVH
`define SCAN_TAP_DEFS_SVH
// Instruction register width and codes
`define IR_W          3
`define IR_EXTEST     3'h0
`define IR_IDCODE     3'h1
`define IR_SAMPLE_Z   3'h2
`define IR_SAMPLE     3'h4
`define IR_BYPASS     3'h7
// Capture-IR pattern in the two low bits
`define IR_CAPTURE    3'h1
// Data register widths
`define ID_W          32
`define BSR_W         71
// Identification value, arbitrary neutral value, low bit marks presence
`define ID_VALUE      32'h1234_5679
// Reset value of the bypass bit
`define BYP_RESET     1'h0
// High mode-select rises that reach test-logic-reset from any state
`define TMS_RESET_LEN 3'h5
`endif

// ### logic/scan_tap_pkg.sv
// Types for the boundary-scan test port
package scan_tap_pkg;
	// Sixteen controller states, one-hot
	typedef enum logic [15:0]
	{
		ST_RESET   = 16'h0001,
		ST_IDLE    = 16'h0002,
		ST_SEL_DR  = 16'h0004,
		ST_CAP_DR  = 16'h0008,
		ST_SH_DR   = 16'h0010,
		ST_EX1_DR  = 16'h0020,
		ST_PAU_DR  = 16'h0040,
		ST_EX2_DR  = 16'h0080,
		ST_UPD_DR  = 16'h0100,
		ST_SEL_IR  = 16'h0200,
		ST_CAP_IR  = 16'h0400,
		ST_SH_IR   = 16'h0800,
		ST_EX1_IR  = 16'h1000,
		ST_PAU_IR  = 16'h2000,
		ST_EX2_IR  = 16'h4000,
		ST_UPD_IR  = 16'h8000
	} tap_state_t;
endpackage

// ### logic/tap_fsm.sv
// Sixteen-state test port controller, advanced on test clock rise events
`include "scan_tap_defs.svh"
module tap_fsm
	import scan_tap_pkg::*;
(
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	// Synchronised test inputs
	input  wire logic                    rise,
	input  wire logic                    mode_sel,
	// Controller state
	output scan_tap_pkg::tap_state_t     state
);
	import scan_tap_pkg::*;

	tap_state_t state_ff;    // Current state
	tap_state_t nxt_state;   // Next state
	logic [2:0] hi_cnt_ff;   // Run of high mode-select rises, saturating
	logic [2:0] nxt_hi_cnt;  // Next run length

	// Next-state decode, moves only on a test clock rise
	always_comb
	begin
		nxt_state = state_ff;
		if (rise)
		begin
			case (state_ff)
				ST_RESET:  nxt_state = mode_sel ? ST_RESET  : ST_IDLE;
				ST_IDLE:   nxt_state = mode_sel ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR: nxt_state = mode_sel ? ST_SEL_IR : ST_CAP_DR;
				ST_CAP_DR: nxt_state = mode_sel ? ST_EX1_DR : ST_SH_DR;
				ST_SH_DR:  nxt_state = mode_sel ? ST_EX1_DR : ST_SH_DR;
				ST_EX1_DR: nxt_state = mode_sel ? ST_UPD_DR : ST_PAU_DR;
				ST_PAU_DR: nxt_state = mode_sel ? ST_EX2_DR : ST_PAU_DR;
				ST_EX2_DR: nxt_state = mode_sel ? ST_UPD_DR : ST_SH_DR;
				ST_UPD_DR: nxt_state = mode_sel ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR: nxt_state = mode_sel ? ST_RESET  : ST_CAP_IR;
				ST_CAP_IR: nxt_state = mode_sel ? ST_EX1_IR : ST_SH_IR;
				ST_SH_IR:  nxt_state = mode_sel ? ST_EX1_IR : ST_SH_IR;
				ST_EX1_IR: nxt_state = mode_sel ? ST_UPD_IR : ST_PAU_IR;
				ST_PAU_IR: nxt_state = mode_sel ? ST_EX2_IR : ST_PAU_IR;
				ST_EX2_IR: nxt_state = mode_sel ? ST_UPD_IR : ST_SH_IR;
				ST_UPD_IR: nxt_state = mode_sel ? ST_SEL_DR : ST_IDLE;
				default:   nxt_state = ST_RESET;
			endcase
		end
	end

	// State register, reset on power-up
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			state_ff <= ST_RESET;
		else
			state_ff <= nxt_state;
	end

	assign state = state_ff;

	// Helper run counter for the reset check, cleared by any low rise
	always_comb
	begin
		nxt_hi_cnt = hi_cnt_ff;
		if (rise)
		begin
			if (!mode_sel)
				nxt_hi_cnt = 3'h0;
			else if (hi_cnt_ff != `TMS_RESET_LEN)
				nxt_hi_cnt = hi_cnt_ff + 3'h1;
		end
	end

	// Run counter register
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			hi_cnt_ff <= 3'h0;
		else
			hi_cnt_ff <= nxt_hi_cnt;
	end

	// Five high mode-select rises reach reset from anywhere
	a_five_tms_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
		(hi_cnt_ff == `TMS_RESET_LEN) |-> state_ff == ST_RESET)
		else $error("reset walk broken");
	a_reset_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_ff == ST_RESET && rise && mode_sel) |=> state_ff == ST_RESET)
		else $error("left reset with mode select high");
	a_onehot_state: assert property (@(posedge ref_clk) disable iff (!nrst)
		$onehot(state_ff))
		else $error("state not one-hot");
endmodule

// ### dv/scan_ctrl_model.sv
// Board-level scan controller model driving the test port pins
`include "scan_tap_defs.svh"
module scan_ctrl_model
(
	// System clock that paces the test clock
	input  wire logic ref_clk,
	// Test port pins
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle pins: clock low, pulled-up lines high
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One 80 ns test clock cycle, entered at a falling system edge; tdo read before the fall
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		repeat (4) @(negedge ref_clk);
		tck = 1'b1;
		repeat (4) @(negedge ref_clk);
		q = tdo;
		tck = 1'b0;
	endtask

	// From Idle into a shift state, n bits LSB first, then back to Idle
	task automatic scan(input logic ir, input int n, input logic [`BSR_W-1:0] din,
		output logic [`BSR_W-1:0] dout, output logic oe_n_seen);
		logic q;
		dout = '0;
		oe_n_seen = 1'b0;
		step(1'b1, 1'b1, q);
		// Extra select step for the instruction path
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		// Last bit leaves through Exit1
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
			oe_n_seen = oe_n_seen | tdo_oe_n;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule

// ### dv/sram_scan_tap_bench.sv
// Self-checking bench of the boundary-scan test port
`include "scan_tap_defs.svh"
module sram_scan_tap_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Shift-in and ring patterns
	localparam logic [`BSR_W-1:0] DIN_PAT  = 71'h6A_5A5A_C3C3_0FF0_9669;
	localparam logic [`BSR_W-1:0] RING_PAT = 71'h35_9C3A_0F5E_A6D1_2B87;
	// Clock, reset and pins
	logic              ref_clk;
	logic              nrst;
	logic              tck;
	logic              tms;
	logic              tdi;
	logic              tdo;
	logic              tdo_oe_n;
	logic [`BSR_W-1:0] ring_in;
	logic              sram_hiz;
	// Counters and scan results
	int                failures;
	int                comparisons;
	logic [`BSR_W-1:0] dout;
	logic              oe_n;
	logic              q;

	// Device under test
	sram_scan_tap sram_scan_tap_i
	(
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdo      (tdo),
		.tdo_oe_n (tdo_oe_n),
		.ring_in  (ring_in),
		.sram_hiz (sram_hiz)
	);
	// Board controller
	scan_ctrl_model scan_ctrl_model_i
	(
		.ref_clk  (ref_clk),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdo      (tdo),
		.tdo_oe_n (tdo_oe_n)
	);

	// System clock
	always #5 ref_clk = ~ref_clk;

	// Bit and vector compares
	task automatic check_bit(input string name, input logic exp, input logic got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %b, seen %b", name, exp, got);
		end
	endtask
	task automatic check_vec(input string name, input logic [`BSR_W-1:0] exp,
		input logic [`BSR_W-1:0] got);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// Counts, verdict, end of run
	task automatic tally_and_finish();
		$display("comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Expected output of a chain of len bits holding cap, fed with din
	function automatic logic [`BSR_W-1:0] chain(input int len, input logic [`BSR_W-1:0] cap,
		input logic [`BSR_W-1:0] din);
		return (din << len) | (cap & ((`BSR_W'(1) << len) - `BSR_W'(1)));
	endfunction

	// Full data scan with enable check
	task automatic dr(input int len, input logic [`BSR_W-1:0] cap);
		scan_ctrl_model_i.scan(1'b0, `BSR_W, DIN_PAT, dout, oe_n);
		check_vec("data chain", chain(len, cap, DIN_PAT), dout);
		check_bit("tdo_oe_n shifting", 1'b0, oe_n);
	endtask

	// Mode-select sequence, LSB first, data low
	task automatic walk(input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++)
			scan_ctrl_model_i.step(m[i], 1'b0, q);
	endtask

	// Power-up state: identification selected, pins quiet
	task automatic t_reset();
		check_bit("hiz", 1'b0, sram_hiz);
		check_bit("tdo_oe_n idle", 1'b1, tdo_oe_n);
		// Leave test-logic-reset for Idle before the first scan
		walk(8'h00, 1);
		dr(`ID_W, `BSR_W'(`ID_VALUE));
	endtask

	// Every code: capture pattern, output gating, selected chain
	task automatic t_codes();
		logic [2:0]        c;
		logic              z;
		int                len;
		logic [`BSR_W-1:0] cap;
		for (int k = 0; k < 8; k++)
		begin
			c = 3'(k);
			z = (c == `IR_EXTEST) || (c == `IR_SAMPLE_Z);
			// Ring held stable across capture
			ring_in = RING_PAT << k;
			scan_ctrl_model_i.scan(1'b1, 3, {68'h0, c}, dout, oe_n);
			check_vec("ir capture", {68'h0, `IR_CAPTURE}, {68'h0, dout[2:0]});
			check_bit("hiz", z, sram_hiz);
			len = (c == `IR_IDCODE) ? `ID_W : 1;
			cap = (c == `IR_IDCODE) ? `BSR_W'(`ID_VALUE) : '0;
			// Boundary chain codes
			if (z || c == `IR_SAMPLE)
			begin
				len = `BSR_W;
				cap = ring_in;
			end
			dr(len, cap);
			check_bit("hiz after update", z, sram_hiz);
		end
	endtask

	// New code waits in Pause-IR, applied only at Update-IR
	task automatic t_pause();
		walk(8'h43, 8);
		check_bit("hiz in pause", 1'b0, sram_hiz);
		walk(8'h03, 3);
		check_bit("hiz updated", 1'b1, sram_hiz);
	endtask

	// Five high mode-select rises from Shift-DR
	task automatic t_tms_reset();
		walk(8'h01, 3);
		walk(8'h1F, 5);
		walk(8'h00, 1);
		check_bit("hiz after reset", 1'b0, sram_hiz);
		dr(`ID_W, `BSR_W'(`ID_VALUE));
	endtask

	// Asynchronous reset in mid-run
	task automatic t_nrst();
		scan_ctrl_model_i.scan(1'b1, 3, {68'h0, `IR_EXTEST}, dout, oe_n);
		check_bit("hiz loaded", 1'b1, sram_hiz);
		nrst = 1'b0;
		repeat (2) @(negedge ref_clk);
		check_bit("hiz in reset", 1'b0, sram_hiz);
		check_bit("tdo_oe_n in reset", 1'b1, tdo_oe_n);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		// Reset leaves the controller in test-logic-reset, step to Idle
		walk(8'h00, 1);
		dr(`ID_W, `BSR_W'(`ID_VALUE));
	endtask

	// Main sequence
	initial
	begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		ring_in = '0;
		failures = 0;
		comparisons = 0;
		repeat (16) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		t_reset();
		t_codes();
		t_pause();
		t_tms_reset();
		t_nrst();
		tally_and_finish();
	end

	// Watchdog, about four times the expected run
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		failures++;
		tally_and_finish();
	end
endmodule
